//--- verilog/wdg_pkg.sv
// Package of constants and types for the countdown watchdog block
package wdg_pkg;
	// ****************************************************
	// Register map (byte addresses, one word each)
	// ****************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;   // Mode, load value / live count, step select
	localparam logic [7:0] REG_IRQ_CFG = 8'h04;   // Per-output enable and pulse mode
	localparam logic [7:0] REG_STATUS = 8'h08;   // Sticky expired flag, write one to clear
	localparam logic [7:0] REG_MASK = 8'h0c;   // Mask for the summary interrupt
	localparam int ADR_W = 8;   // Decoded address width

	// ****************************************************
	// Field layout
	// ****************************************************
	localparam int CNT_W = 5;   // Down-counter width
	localparam int STEP_W = 2;   // Step select width
	localparam int CTRL_STEP_LSB = 0;   // Step select position
	localparam int CTRL_CNT_LSB = 2;   // Count field position
	localparam int CTRL_REP_BIT = 7;   // Repeat mode bit
	localparam int CFG_EN_A_BIT = 0;   // Output A enable
	localparam int CFG_EN_B_BIT = 1;   // Output B enable
	localparam int CFG_PULSE_A_BIT = 2;   // Output A pulse mode
	localparam int CFG_PULSE_B_BIT = 3;   // Output B pulse mode
	localparam int STAT_FLAG_BIT = 0;   // Expired flag position

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [CNT_W-1:0] RST_COUNT = 5'h00;   // Stopped, count zero
	localparam logic [STEP_W-1:0] RST_STEP = 2'h0;   // Four second step
	localparam logic RST_REPEAT = 1'b0;   // Single shot

	// ****************************************************
	// Step selection and oscillator division
	// ****************************************************
	localparam logic [STEP_W-1:0] STEP_4S = 2'h0;   // 0.25 Hz
	localparam logic [STEP_W-1:0] STEP_1S = 2'h1;   // 1 Hz
	localparam logic [STEP_W-1:0] STEP_QUARTER = 2'h2;   // 4 Hz
	localparam logic [STEP_W-1:0] STEP_SIXTEENTH = 2'h3;   // 16 Hz
	localparam int DIV_W = 18;   // Oscillator tick counter width
	localparam int TAP_4S = 17;   // 131072 ticks of 32.768 kHz
	localparam int TAP_1S = 15;   // 32768 ticks
	localparam int TAP_QUARTER = 13;   // 8192 ticks
	localparam int TAP_SIXTEENTH = 11;   // 2048 ticks

	// ****************************************************
	// Countdown state
	// ****************************************************
	typedef enum logic {
		WD_STOP = 1'b0,   // Idle, count holds zero
		WD_RUN = 1'b1   // Counting down
	} wdg_state_type;
endpackage

//--- verilog/wdg_step_div.sv
// Step clock divider fed by the corrected 32.768 kHz oscillator ticks
`timescale 1ns/10ps
`default_nettype none
module wdg_step_div
	import wdg_pkg::*;
(
	input wire logic clk,   // System clock
	input wire logic rst_n,   // Synchronous reset, active low
	input wire logic osc_tick,   // One pulse per oscillator cycle
	input wire logic corr_add,   // Correction: insert one tick
	input wire logic corr_skip,   // Correction: drop one tick
	input wire logic [STEP_W-1:0] step_sel,   // Selected step size
	output logic step_tick   // One pulse per step
);
	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		logic [DIV_W-1:0] cnt;   // Corrected tick count
	} wdg_div_type;

	wdg_div_type cur;   // Registered state
	wdg_div_type next_cur;   // Next state
	logic [1:0] inc;   // Ticks advanced this cycle
	logic [3:0] tap_edge;   // Carry into each tap bit
	localparam int TAPS [4] = '{TAP_4S, TAP_1S, TAP_QUARTER, TAP_SIXTEENTH};

	// ****************************************************
	// Correction and division
	// ****************************************************
	// Corrections act on the tick stream before division, so every step is corrected
	always_comb begin
		inc = {1'b0, osc_tick & ~corr_skip} + {1'b0, corr_add};
		next_cur.cnt = cur.cnt + {{(DIV_W-2){1'b0}}, inc};
	end

	// Advance is at most two, so a carry into a tap is never jumped over
	for (genvar i = 0; i < 4; i++) begin : g_tap
		assign tap_edge[i] = next_cur.cnt[TAPS[i]] ^ cur.cnt[TAPS[i]];
	end

	assign step_tick = tap_edge[step_sel];

	// Register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur.cnt <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule
`default_nettype wire

//--- verilog/wdg_top.sv
// Countdown watchdog with Wishbone registers and two interrupt outputs
//
// Behaviour
// - Five-bit counter decrements each step tick
// - Loading zero stops countdown, no expiries
// - Nonzero load starts; software loads 1..31
// - New load replaces running count immediately
// - Only first period may be one step short
// - Count field reads live counter value
// - Repeat mode: set flag, reload, continue
// - Flag stays set until host clears it
// - Single shot: set flag, halt at zero
// - Each output has its own enable
// - Pulse mode pulses at every expiry
// - Level mode follows the expired flag
// - Step clocks divided from oscillator only
// - Step clock taken after offset correction
// - Step select: 4s, 1s, 1/4s, 1/16s
// - Period equals count times step length
`timescale 1ns/10ps
`default_nettype none
module wdg_top
	import wdg_pkg::*;
(
	input wire logic REF_CLK,   // 20 MHz system clock
	input wire logic RST_N,   // Synchronous reset, active low
	input wire logic OSC_TICK,   // 32.768 kHz oscillator tick pulse
	input wire logic CORR_ADD,   // Offset correction: add a tick
	input wire logic CORR_SKIP,   // Offset correction: skip a tick
	input wire logic WB_CYC_I,   // Wishbone cycle
	input wire logic WB_STB_I,   // Wishbone strobe
	input wire logic WB_WE_I,   // Wishbone write enable
	input wire logic [ADR_W-1:0] WB_ADR_I,   // Wishbone byte address
	input wire logic [3:0] WB_SEL_I,   // Wishbone byte selects
	input wire logic [31:0] WB_DAT_I,   // Wishbone write data
	output logic [31:0] WB_DAT_O,   // Wishbone read data
	output logic WB_ACK_O,   // Wishbone acknowledge
	output logic IRQ_OUT_A,   // Watchdog interrupt output A
	output logic IRQ_OUT_B,   // Watchdog interrupt output B
	output logic IRQ   // Summary interrupt, masked status
);
	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		wdg_state_type st;   // Run or stop
		logic [CNT_W-1:0] count;   // Live down-counter
		logic [CNT_W-1:0] reload;   // Last loaded value
		logic repeat_mode;   // wd_repeat_select
		logic [STEP_W-1:0] step;   // wd_step_select
		logic flag;   // wd_expired_flag
		logic mask;   // Summary interrupt mask
		logic en_a;   // wd_irq_enable_a
		logic en_b;   // wd_irq_enable_b
		logic pulse_a;   // Output A in pulse mode
		logic pulse_b;   // Output B in pulse mode
		logic pls_a;   // Pending pulse on output A
		logic pls_b;   // Pending pulse on output B
		logic ack;   // Bus acknowledge
		logic [31:0] dat;   // Read data
	} wdg_regs_type;

	wdg_regs_type cur;   // Registered state
	wdg_regs_type next_cur;   // Next state
	logic step_tick;   // Step clock pulse
	logic req;   // New bus request
	logic wr_lo;   // Write to low byte
	logic wr_ctrl;   // Load write to control
	logic clr_req;   // Write one to flag
	logic expire;   // End of a period this cycle
	logic [CNT_W-1:0] load_val;   // Value being loaded

	// ****************************************************
	// Step clock
	// ****************************************************
	wdg_step_div u_div (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.osc_tick(OSC_TICK),
		.corr_add(CORR_ADD),
		.corr_skip(CORR_SKIP),
		.step_sel(cur.step),
		.step_tick(step_tick)
	);

	// ****************************************************
	// Bus decode
	// ****************************************************
	// A request is taken once; ack drops the cycle after it was given
	assign req = WB_CYC_I & WB_STB_I & ~cur.ack;
	assign wr_lo = req & WB_WE_I & WB_SEL_I[0];
	assign wr_ctrl = wr_lo & (WB_ADR_I == REG_CTRL);
	assign clr_req = wr_lo & (WB_ADR_I == REG_STATUS) & WB_DAT_I[STAT_FLAG_BIT];
	assign load_val = WB_DAT_I[CTRL_CNT_LSB +: CNT_W];
	// Expiry is the step that arrives while the count is one
	assign expire = (cur.st == WD_RUN) & step_tick & (cur.count == 5'h01);

	// ****************************************************
	// Next state
	// ****************************************************
	// One process builds every next value; a field holds unless a default or branch
	// below moves it, so no latch can form
	always_comb begin
		next_cur = cur;
		// Ack and pulses are one-cycle strobes and fall back by default
		next_cur.ack = req;
		next_cur.pls_a = 1'b0;
		next_cur.pls_b = 1'b0;
		// Countdown
		unique case (cur.st)
			WD_STOP: begin
				next_cur.count = RST_COUNT;
			end
			WD_RUN: begin
				if (expire) begin
					next_cur.flag = 1'b1;
					if (cur.repeat_mode) begin
						next_cur.count = cur.reload;
					end else begin
						next_cur.count = RST_COUNT;
						next_cur.st = WD_STOP;
					end
				end else if (step_tick) begin
					next_cur.count = cur.count - 5'h01;
				end
			end
		endcase
		// Per-output pulse on every expiry, whatever the flag holds
		if (expire) begin
			next_cur.pls_a = cur.en_a & cur.pulse_a;
			next_cur.pls_b = cur.en_b & cur.pulse_b;
		end
		// Load wins over a coinciding step; divider phase is kept, so only
		// the first period can come up to one step short
		if (wr_ctrl) begin
			next_cur.repeat_mode = WB_DAT_I[CTRL_REP_BIT];
			next_cur.step = WB_DAT_I[CTRL_STEP_LSB +: STEP_W];
			next_cur.reload = load_val;
			next_cur.count = load_val;
			next_cur.st = (load_val == RST_COUNT) ? WD_STOP : WD_RUN;
		end
		if (wr_lo && WB_ADR_I == REG_IRQ_CFG) begin
			next_cur.en_a = WB_DAT_I[CFG_EN_A_BIT];
			next_cur.en_b = WB_DAT_I[CFG_EN_B_BIT];
			next_cur.pulse_a = WB_DAT_I[CFG_PULSE_A_BIT];
			next_cur.pulse_b = WB_DAT_I[CFG_PULSE_B_BIT];
		end
		if (wr_lo && WB_ADR_I == REG_MASK) begin
			next_cur.mask = WB_DAT_I[STAT_FLAG_BIT];
		end
		// Only the clear command drops the flag, and a new expiry wins
		if (clr_req && !expire) begin
			next_cur.flag = 1'b0;
		end
		// Read data, unmapped addresses read zero
		next_cur.dat = '0;
		if (req && !WB_WE_I) begin
			unique case (WB_ADR_I)
				REG_CTRL: begin
					next_cur.dat[CTRL_REP_BIT] = cur.repeat_mode;
					next_cur.dat[CTRL_CNT_LSB +: CNT_W] = cur.count;
					next_cur.dat[CTRL_STEP_LSB +: STEP_W] = cur.step;
				end
				REG_IRQ_CFG: begin
					next_cur.dat[CFG_EN_A_BIT] = cur.en_a;
					next_cur.dat[CFG_EN_B_BIT] = cur.en_b;
					next_cur.dat[CFG_PULSE_A_BIT] = cur.pulse_a;
					next_cur.dat[CFG_PULSE_B_BIT] = cur.pulse_b;
				end
				REG_STATUS: begin
					next_cur.dat[STAT_FLAG_BIT] = cur.flag;
				end
				REG_MASK: begin
					next_cur.dat[STAT_FLAG_BIT] = cur.mask;
				end
				default: begin
					next_cur.dat = '0;
				end
			endcase
		end
	end

	// ****************************************************
	// Register
	// ****************************************************
	// Synchronous reset; the struct clear also covers enables, mask and flag,
	// so no interrupt output can be high in the first cycle after reset
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			cur <= '0;
			cur.st <= WD_STOP;
			cur.count <= RST_COUNT;
			cur.reload <= RST_COUNT;
			cur.repeat_mode <= RST_REPEAT;
			cur.step <= RST_STEP;
		end else begin
			cur <= next_cur;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	// Level mode follows the flag; pulse mode is one clock per expiry
	assign IRQ_OUT_A = cur.en_a & (cur.pulse_a ? cur.pls_a : cur.flag);
	assign IRQ_OUT_B = cur.en_b & (cur.pulse_b ? cur.pls_b : cur.flag);
	assign IRQ = cur.flag & cur.mask;
	assign WB_ACK_O = cur.ack;
	assign WB_DAT_O = cur.dat;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Reset switches off every check except the one that looks at reset

	AST_DECREMENT: assert property (
		(cur.st == WD_RUN && step_tick && cur.count > 5'h01 && !wr_ctrl)
		|=> cur.count == $past(cur.count) - 5'h01)
		else $error("count did not step down");
	AST_ZERO_STOPS: assert property (
		(wr_ctrl && load_val == 5'h00) |=> (cur.st == WD_STOP) [*2] ##0 !expire)
		else $error("zero load did not stop");
	AST_LOAD_STARTS: assert property (
		(wr_ctrl && load_val != 5'h00)
		|=> cur.st == WD_RUN && cur.count == $past(load_val) && cur.reload == cur.count)
		else $error("load did not start countdown");
	AST_STOP_QUIET: assert property (
		cur.st == WD_STOP |-> !expire && cur.count == 5'h00)
		else $error("expiry while stopped");
	AST_REPEAT_RELOAD: assert property (
		(expire && cur.repeat_mode && !wr_ctrl)
		|=> cur.flag && cur.st == WD_RUN && cur.count == cur.reload)
		else $error("repeat expiry did not reload");
	AST_SINGLE_HALT: assert property (
		(expire && !cur.repeat_mode && !wr_ctrl)
		|=> cur.flag && cur.st == WD_STOP && cur.count == 5'h00)
		else $error("single shot did not halt");
	AST_FLAG_STICKY: assert property (
		(cur.flag && !clr_req) |=> cur.flag)
		else $error("flag dropped without clear");
	AST_LEVEL_A: assert property (
		!cur.pulse_a |-> IRQ_OUT_A == (cur.en_a && cur.flag))
		else $error("level output A differs from flag");
	AST_PULSE_A: assert property (
		(expire && cur.en_a && cur.pulse_a) |=> IRQ_OUT_A ##1 !IRQ_OUT_A)
		else $error("missing pulse on output A");
	AST_DISABLED_B: assert property (
		!cur.en_b |-> !IRQ_OUT_B)
		else $error("disabled output B active");
	AST_READ_LIVE: assert property (
		(req && !WB_WE_I && WB_ADR_I == REG_CTRL)
		|=> WB_ACK_O && WB_DAT_O[CTRL_CNT_LSB +: CNT_W] == $past(cur.count))
		else $error("count read is not live value");
	// Interrupt outputs: the B side mirrors the checks on A, so each
	// output is tied to its own enable and mode bits
	AST_LEVEL_B: assert property (
		(cur.en_b && !cur.pulse_b) |-> IRQ_OUT_B == cur.flag)
		else $error("level output B differs from flag");
	AST_PULSE_B: assert property (
		(expire && cur.en_b && cur.pulse_b) |=> IRQ_OUT_B ##1 !IRQ_OUT_B)
		else $error("missing pulse on output B");
	AST_DISABLED_A: assert property (
		!cur.en_a |-> !IRQ_OUT_A)
		else $error("disabled output A active");
	// A pulse output stays low except in the cycle after an expiry
	AST_PULSE_QUIET_A: assert property (
		(cur.pulse_a && !$past(expire)) |-> !IRQ_OUT_A)
		else $error("pulse on output A without expiry");
	AST_PULSE_QUIET_B: assert property (
		(cur.pulse_b && !$past(expire)) |-> !IRQ_OUT_B)
		else $error("pulse on output B without expiry");
	// The flag has exactly one source and one sink
	AST_FLAG_SOURCE: assert property (
		(!cur.flag && !expire) |=> !cur.flag)
		else $error("flag set without expiry");
	AST_FLAG_CLEAR: assert property (
		(clr_req && !expire) |=> !cur.flag)
		else $error("clear command did not drop flag");
	AST_SET_WINS: assert property (
		(expire && clr_req) |=> cur.flag)
		else $error("clear overrode a new expiry");
	// Count moves only on a step tick or a load
	AST_COUNT_HOLDS: assert property (
		(cur.st == WD_RUN && !step_tick && !wr_ctrl) |=> $stable(cur.count))
		else $error("count moved without a step");
	// Reset is checked with the default disable switched off
	AST_RESET_STATE: assert property (disable iff (1'b0)
		!RST_N |=> cur.st == WD_STOP && cur.count == RST_COUNT && !cur.flag
		&& cur.repeat_mode == RST_REPEAT && cur.step == RST_STEP
		&& !IRQ_OUT_A && !IRQ_OUT_B && !IRQ)
		else $error("reset state wrong");

	// ****************************************************
	// Cover points
	// ****************************************************
	// A repeat expiry that reloads is the heart of the periodic use
	COV_REPEAT: cover property (expire && cur.repeat_mode ##1 cur.count == cur.reload);
	COV_PULSE_B: cover property (expire && cur.en_b && cur.pulse_b ##1 IRQ_OUT_B);
	COV_SINGLE: cover property (expire && !cur.repeat_mode);
	COV_PULSE_ON_FLAG: cover property (cur.flag && expire && cur.en_a && cur.pulse_a);
	COV_RELOAD_MID: cover property (cur.st == WD_RUN && cur.count > 5'h01 && wr_ctrl);
endmodule
`default_nettype wire

//--- bench/wdg_host_model.sv
// Host processor model driving the watchdog registers over classic Wishbone
`timescale 1ns/10ps
`default_nettype none
module wdg_host_model (
	input wire logic clk,   // System clock
	output logic cyc,   // Cycle
	output logic stb,   // Strobe
	output logic we,   // Write enable
	output logic [7:0] adr,   // Byte address
	output logic [3:0] sel,   // Byte selects
	output logic [31:0] dat_w,   // Write data
	input wire logic [31:0] dat_r,   // Read data
	input wire logic ack   // Acknowledge
);
	// ****************************************************
	// Bus cycles
	// ****************************************************
	initial begin
		{cyc, stb, we, adr, sel, dat_w} = '0;
	end

	// One classic cycle: hold everything until ack is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_w <= d;
		// No limit here: only the run watchdog ends a wait that never answers
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		// Released data must not look like a still valid word
		dat_w <= ~d;
		adr <= ~a;
	endtask

	// Live count cannot be frozen, so accept only two agreeing reads
	task automatic read_twice(input logic [7:0] a, output logic [31:0] q);
		logic [31:0] p;
		xfer(1'b0, a, 32'h0, p);
		xfer(1'b0, a, 32'h0, q);
		while (p !== q) begin
			p = q;
			xfer(1'b0, a, 32'h0, q);
		end
	endtask
endmodule
`default_nettype wire

//--- bench/wdg_top_test.sv
// Self-checking testbench of the countdown watchdog
`timescale 1ns/10ps
`default_nettype none
module wdg_top_test;
	import wdg_pkg::*;
	logic ref_clk, rst_n, osc_tick, cyc, stb, we, ack, irq_a, irq_b, irq;   // Pins
	logic corr_add, corr_skip;   // Offset correction pulses
	logic [7:0] adr;   // Address
	logic [3:0] sel;   // Selects
	logic [31:0] dat_w, dat_r, q;   // Data
	int err_total = 0;   // Mismatches
	int checks_done = 0;   // Comparisons
	int seed = 40;   // Random seed
	int cnt = 0;   // Cycle counter
	int t0, v;   // Start stamp, load value
	int stamp[$];   // Cycles of expiry pulses on output B
	int stamp_a[$];   // Cycles at which output A is high
	wdg_top dut (.REF_CLK(ref_clk), .RST_N(rst_n), .OSC_TICK(osc_tick), .CORR_ADD(corr_add),
		.CORR_SKIP(corr_skip), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
		.IRQ_OUT_A(irq_a), .IRQ_OUT_B(irq_b), .IRQ(irq));
	wdg_host_model host (.clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat_w(dat_w), .dat_r(dat_r), .ack(ack));

	// ****************************************************
	// Clock, pulse recorder, watchdog
	// ****************************************************
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Oscillator ticks every cycle so a sixteenth step is 2048 cycles
	always @(posedge ref_clk) begin
		cnt <= cnt + 1;
		if (irq_b === 1'b1) stamp.push_back(cnt);
		if (irq_a === 1'b1) stamp_a.push_back(cnt);
	end
	// Run needs about 40000 cycles; cut a hang well beyond that
	initial begin
		repeat (90000) @(posedge ref_clk);
		err_total++;
		final_report();
	end

	// ****************************************************
	// Helpers
	// ****************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		host.xfer(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	// Control word from mode, count and step
	function automatic logic [31:0] ctl(input logic r, input logic [4:0] c, input logic [1:0] s);
		return {24'h0, r, c, s};
	endfunction
	// Wait for k recorded pulses, bounded
	task automatic wait_pulses(input int k, input int lim);
		int t;
		t = 0;
		while (stamp.size() < k && t < lim) begin
			@(posedge ref_clk);
			t++;
		end
		chk("pulse arrival", 1, stamp.size() >= k);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		rst_n = 1'b0;
		osc_tick = 1'b1;
		corr_add = 1'b0;
		corr_skip = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(REG_CTRL, "ctrl reset", ctl(RST_REPEAT, RST_COUNT, RST_STEP));
		rd(REG_STATUS, "status reset", 32'h0);
		chk("outputs reset", 3'b000, {irq_a, irq_b, irq});
		rd(8'h40, "unmapped", 32'h0);
		$display("test reset done");
		// A level, B pulse, summary unmasked
		wr(REG_IRQ_CFG, 32'h0b);
		wr(REG_MASK, 32'h01);
		stamp.delete();
		wr(REG_CTRL, ctl(1'b0, 5'd2, STEP_SIXTEENTH));
		t0 = cnt;
		wait_pulses(1, 4200);
		chk("single period", 1, stamp[0] - t0 >= 2048 && stamp[0] - t0 <= 4104);
		repeat (6144) @(posedge ref_clk);
		chk("single halts", 1, stamp.size());
		rd(REG_CTRL, "single count", ctl(1'b0, 5'd0, STEP_SIXTEENTH));
		rd(REG_STATUS, "flag held", 32'h1);
		chk("level and summary", 2'b11, {irq_a, irq});
		wr(REG_STATUS, 32'h1);
		rd(REG_STATUS, "flag cleared", 32'h0);
		chk("level follows flag", 2'b00, {irq_a, irq});
		$display("test single shot done");
		// Both outputs in pulse mode until output A is disabled in the reload test
		wr(REG_IRQ_CFG, 32'h0f);
		stamp.delete();
		stamp_a.delete();
		wr(REG_CTRL, ctl(1'b1, 5'd1, STEP_SIXTEENTH));
		wait_pulses(3, 8300);
		chk("repeat spacing 1", 2048, stamp[1] - stamp[0]);
		chk("repeat spacing 2", 2048, stamp[2] - stamp[1]);
		chk("pulse with flag set", 3, stamp.size());
		chk("pulse count on A", stamp.size(), stamp_a.size());
		chk("pulse time on A", stamp[2], stamp_a[2]);
		// One inserted tick shortens the next period, one dropped tick stretches it
		corr_add <= 1'b1;
		@(posedge ref_clk);
		corr_add <= 1'b0;
		wait_pulses(4, 2200);
		chk("corrected period add", 2047, stamp[3] - stamp[2]);
		corr_skip <= 1'b1;
		@(posedge ref_clk);
		corr_skip <= 1'b0;
		wait_pulses(5, 2200);
		chk("corrected period skip", 2049, stamp[4] - stamp[3]);
		$display("test repeat done");
		wr(REG_CTRL, ctl(1'b1, 5'd0, STEP_SIXTEENTH));
		wr(REG_STATUS, 32'h1);
		stamp.delete();
		repeat (6144) @(posedge ref_clk);
		chk("stopped pulses", 0, stamp.size());
		rd(REG_STATUS, "stopped flag", 32'h0);
		$display("test stop done");
		v = 20 + ($unsigned($random(seed)) % 12);
		wr(REG_CTRL, ctl(1'b0, v[4:0], STEP_SIXTEENTH));
		repeat (11240) @(posedge ref_clk);
		host.read_twice(REG_CTRL, q);
		chk("live count", 1, q[6:2] == v - 5 || q[6:2] == v - 6);
		stamp.delete();
		wr(REG_CTRL, ctl(1'b0, 5'd1, STEP_SIXTEENTH));
		t0 = cnt;
		wait_pulses(1, 2200);
		chk("reload at once", 1, stamp[0] - t0 <= 2056);
		wr(REG_IRQ_CFG, 32'h0a);
		@(posedge ref_clk);
		chk("disabled output", 1'b0, irq_a);
		$display("test reload done");
		final_report();
	end
endmodule
`default_nettype wire
